/* common/usb_xcvr_cfg.svh */
// How it works
// - Eight endpoint pipes: control IN/OUT plus three IN/OUT pairs.
// - Control endpoint is bidirectional and answers at protocol address zero.
// - Endpoints one to three answer IN at 0x81-0x83, OUT at 0x01-0x03.
// - Speed bit one selects full speed, pull-up on D+.
// - Speed bit zero selects low speed, pull-up on D-.
// - Pull-up is applied only while bus power is detected.
// - Bit 7 clear detaches; set attaches the pull-up when bus power present.
// - Bit 6 enables the transceiver; clear puts it in suspend.
// - Test field: 00 normal, 01 D+ high, 10 D- high, 11 both low.
// - Bit 2 reads the differential receiver, valid while transceiver enabled.
// - Bit 1 reads the sampled D+ level.
// - Bit 0 reads the sampled D- level.
// - The controller acts only as a USB function, never as a host.
`ifndef USB_XCVR_CFG_SVH
`define USB_XCVR_CFG_SVH
`define XCVR_CTRL_ADDR 8'hd7
`define XCVR_CTRL_RESET 8'h00
`define XCVR_BIT_PULLUP 7
`define XCVR_BIT_PHY_ENABLE 6
`define XCVR_BIT_SPEED 5
`define XCVR_BIT_TST_HI 4
`define XCVR_BIT_TST_LO 3
`define XCVR_BIT_DIFF 2
`define XCVR_BIT_DPLUS 1
`define XCVR_BIT_DMINUS 0
`define XCVR_WR_MASK 8'hf8
`define EP_PIPE_COUNT 8
`define EP_IN_FLAG 8'h80
`define EP_LAST 2'h3
`endif

/* common/usb_xcvr_pkg.sv */
`default_nettype none
package usb_xcvr_pkg;
   typedef enum logic [1:0] {
      test_normal_type = 2'b00,
      test_diff_one_type = 2'b01,
      test_diff_zero_type = 2'b10,
      test_se_zero_type = 2'b11
   } phy_test_mode_type;
endpackage
`default_nettype wire

/* hw/endpoint_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_xcvr_cfg.svh"
module endpoint_decode (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Token endpoint and direction.
   input wire logic [3:0] ep_num_i,
   input wire logic ep_dir_in_i,
   // Result.
   output logic ep_hit_o,
   output logic [7:0] ep_addr_o,
   output logic [2:0] ep_pipe_o
);
   logic hit_d, hit_q;
   logic [7:0] addr_d, addr_q;
   logic [2:0] pipe_d, pipe_q;
   always_comb begin
      hit_d = 1'b0;
      addr_d = 8'h00;
      pipe_d = 3'h0;
      if (ep_num_i == 4'h0) begin
         hit_d = 1'b1;
         addr_d = 8'h00;
         pipe_d = {2'b00, ep_dir_in_i};
      end else if (ep_num_i <= {2'b00, `EP_LAST}) begin
         hit_d = 1'b1;
         addr_d = (ep_dir_in_i ? `EP_IN_FLAG : 8'h00) | {4'h0, ep_num_i};
         pipe_d = {ep_num_i[1:0], ep_dir_in_i};
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         hit_q <= 1'b0;
         addr_q <= 8'h00;
         pipe_q <= 3'h0;
      end else begin
         hit_q <= hit_d;
         addr_q <= addr_d;
         pipe_q <= pipe_d;
      end
   end
   assign ep_hit_o = hit_q;
   assign ep_addr_o = addr_q;
   assign ep_pipe_o = pipe_q;
endmodule
`default_nettype wire

/* hw/line_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Data.
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q, meta_d, sync_q, sync_d;
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_o = sync_q;
endmodule
`default_nettype wire

/* hw/usb_transceiver_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_xcvr_cfg.svh"
// ****************************************************************
// Transceiver control register and line control.
// ****************************************************************
module usb_transceiver_control
   import usb_xcvr_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Line inputs from the transceiver.
   input wire logic dplus_i,
   input wire logic dminus_i,
   input wire logic diff_rx_i,
   input wire logic vbus_present_i,
   // Line drive.
   output logic dplus_o,
   output logic dplus_oe_o,
   output logic dminus_o,
   output logic dminus_oe_o,
   // Transceiver control.
   output logic phy_enable_o,
   output logic full_speed_o,
   output logic pullup_dplus_o,
   output logic pullup_dminus_o,
   output logic host_mode_o,
   // Endpoint decode.
   input wire logic [3:0] ep_num_i,
   input wire logic ep_dir_in_i,
   output logic ep_hit_o,
   output logic [7:0] ep_addr_o,
   output logic [2:0] ep_pipe_o
);
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] rdata_q, rdata_d;
   logic [2:0] line_sync;
   logic pullup_enable, phy_enable, speed;
   phy_test_mode_type phy_test_mode;
   logic diff_receiver_state, dplus_level, dminus_level;
   logic dp_q, dp_d, dpoe_q, dpoe_d, dn_q, dn_d, dnoe_q, dnoe_d;
   logic pud_q, pud_d, pun_q, pun_d, en_q, en_d, fs_q, fs_d;
   logic wr_sel, rd_sel;
   logic [2:0] status_bits;
   logic [3:0] drive_d;
   logic host_q, host_d;

   // ****************************************************************
   // Register decoding.
   // ****************************************************************
   // Shared by the read and the write path.
   function automatic logic ctrl_sel(input logic [7:0] addr);
      ctrl_sel = (addr == `XCVR_CTRL_ADDR);
   endfunction

   // Writable bits come from the register, status bits from the lines.
   function automatic logic [7:0] readback_byte(input logic [7:0] ctrl,
      input logic [2:0] status);
      logic [7:0] value;
      value = ctrl & `XCVR_WR_MASK;
      value[`XCVR_BIT_DIFF] = status[2];
      value[`XCVR_BIT_DPLUS] = status[1];
      value[`XCVR_BIT_DMINUS] = status[0];
      readback_byte = value;
   endfunction

   // ****************************************************************
   // Line decoding.
   // ****************************************************************
   // Returns the D+ pull-up, then the D- pull-up.
   function automatic logic [1:0] pullup_place(input logic enable, input logic power,
      input logic full_speed);
      logic attach;
      attach = enable & power;
      pullup_place = {attach & full_speed, attach & ~full_speed};
   endfunction

   // Forced line test modes.
   // Returns D+ level, D- level, D+ enable and D- enable.
   function automatic logic [3:0] line_drive(input phy_test_mode_type mode);
      logic [3:0] drive;
      drive = 4'h0;
      unique case (mode)
         test_normal_type: begin
            drive[3] = 1'b0;
            drive[2] = 1'b0;
            drive[1] = 1'b0;
            drive[0] = 1'b0;
         end
         test_diff_one_type: begin
            drive[3] = 1'b1;
            drive[2] = 1'b0;
            drive[1] = 1'b1;
            drive[0] = 1'b1;
         end
         test_diff_zero_type: begin
            drive[3] = 1'b0;
            drive[2] = 1'b1;
            drive[1] = 1'b1;
            drive[0] = 1'b1;
         end
         test_se_zero_type: begin
            drive[3] = 1'b0;
            drive[2] = 1'b0;
            drive[1] = 1'b1;
            drive[0] = 1'b1;
         end
      endcase
      line_drive = drive;
   endfunction

   // ****************************************************************
   // Register.
   // ****************************************************************
   assign pullup_enable = ctrl_q[`XCVR_BIT_PULLUP];
   assign phy_enable = ctrl_q[`XCVR_BIT_PHY_ENABLE];
   assign speed = ctrl_q[`XCVR_BIT_SPEED];
   assign phy_test_mode = phy_test_mode_type'(ctrl_q[`XCVR_BIT_TST_HI:`XCVR_BIT_TST_LO]);
   assign diff_receiver_state = line_sync[2];
   assign dplus_level = line_sync[1];
   assign dminus_level = line_sync[0];

   line_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .async_i({diff_rx_i, dplus_i, dminus_i}),
      .sync_o(line_sync)
   );

   // ****************************************************************
   // Line status.
   // ****************************************************************
   // Differential bit reads zero while the transceiver is off.
   assign status_bits[`XCVR_BIT_DIFF] = phy_enable & diff_receiver_state;
   assign status_bits[`XCVR_BIT_DPLUS] = dplus_level;
   assign status_bits[`XCVR_BIT_DMINUS] = dminus_level;

   // ****************************************************************
   // Control register.
   // ****************************************************************
   assign wr_sel = reg_wr_i & ctrl_sel(reg_addr_i);
   assign rd_sel = reg_rd_i & ctrl_sel(reg_addr_i);

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_sel) begin
         ctrl_d = reg_wdata_i & `XCVR_WR_MASK;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl_q <= `XCVR_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ****************************************************************
   // Read data.
   // ****************************************************************
   // Reads of other addresses answer zero; the byte holds until the next read.
   always_comb begin
      rdata_d = rdata_q;
      if (rd_sel) begin
         rdata_d = readback_byte(ctrl_q, status_bits);
      end else if (reg_rd_i) begin
         rdata_d = 8'h00;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Line control.
   // ****************************************************************
   always_comb begin
      en_d = phy_enable;
      fs_d = speed;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         fs_q <= 1'b0;
      end else begin
         en_q <= en_d;
         fs_q <= fs_d;
      end
   end

   // ****************************************************************
   // Pull-ups.
   // ****************************************************************
   always_comb begin
      {pud_d, pun_d} = pullup_place(pullup_enable, vbus_present_i, speed);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pud_q <= 1'b0;
         pun_q <= 1'b0;
      end else begin
         pud_q <= pud_d;
         pun_q <= pun_d;
      end
   end

   // ****************************************************************
   // Forced line drive.
   // ****************************************************************
   // Mode zero releases both lines to the pull-ups and the host.
   always_comb begin
      drive_d = line_drive(phy_test_mode);
      dp_d = drive_d[3];
      dn_d = drive_d[2];
      dpoe_d = drive_d[1];
      dnoe_d = drive_d[0];
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         dp_q <= 1'b0;
         dn_q <= 1'b0;
         dpoe_q <= 1'b0;
         dnoe_q <= 1'b0;
      end else begin
         dp_q <= dp_d;
         dn_q <= dn_d;
         dpoe_q <= dpoe_d;
         dnoe_q <= dnoe_d;
      end
   end

   // ****************************************************************
   // Endpoint addressing.
   // ****************************************************************
   endpoint_decode u_ep (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ep_num_i(ep_num_i),
      .ep_dir_in_i(ep_dir_in_i),
      .ep_hit_o(ep_hit_o),
      .ep_addr_o(ep_addr_o),
      .ep_pipe_o(ep_pipe_o)
   );

   // ****************************************************************
   // Role.
   // ****************************************************************
   // Kept as a flop so that every output leaves a register.
   // Function role only.
   always_comb begin
      host_d = 1'b0;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         host_q <= 1'b0;
      end else begin
         host_q <= host_d;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign reg_rdata_o = rdata_q;
   assign phy_enable_o = en_q;
   assign full_speed_o = fs_q;
   assign pullup_dplus_o = pud_q;
   assign pullup_dminus_o = pun_q;
   assign dplus_o = dp_q;
   assign dminus_o = dn_q;
   assign dplus_oe_o = dpoe_q;
   assign dminus_oe_o = dnoe_q;
   assign host_mode_o = host_q;
endmodule
`default_nettype wire

/* verification/usb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Host side of the lines.
// ****
module usb_host_model (
   // Device side.
   input wire logic dplus_o,
   input wire logic dplus_oe_o,
   input wire logic dminus_o,
   input wire logic dminus_oe_o,
   input wire logic pullup_dplus_o,
   input wire logic pullup_dminus_o,
   // Host drive enable, plus level, minus level.
   input wire logic [2:0] host_i,
   // Line levels.
   output logic dplus_i,
   output logic dminus_i,
   output logic diff_rx_i
);
   always_comb begin
      dplus_i = dplus_oe_o ? dplus_o : host_i[2] ? host_i[1] : pullup_dplus_o;
      dminus_i = dminus_oe_o ? dminus_o : host_i[2] ? host_i[0] : pullup_dminus_o;
      diff_rx_i = dplus_i && !dminus_i;
   end
endmodule
`default_nettype wire

/* verification/usb_transceiver_control_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker.
// ****
module usb_xcvr_checker (
   // Watched ports.
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic vbus_present_i,
   input wire logic dplus_o,
   input wire logic dplus_oe_o,
   input wire logic dminus_o,
   input wire logic dminus_oe_o,
   input wire logic phy_enable_o,
   input wire logic full_speed_o,
   input wire logic pullup_dplus_o,
   input wire logic pullup_dminus_o
);
   wire logic wr_hit = reg_wr_i && reg_addr_i == 8'hd7;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   AST_PHY:
   assert property (wr_hit |-> ##2 phy_enable_o == $past(reg_wdata_i[6], 2))
      else $error("phy enable");
   AST_SPEED:
   assert property (wr_hit |-> ##2 full_speed_o == $past(reg_wdata_i[5], 2))
      else $error("speed");
   AST_DETACH:
   assert property (wr_hit && !reg_wdata_i[7] |-> ##2 !pullup_dplus_o && !pullup_dminus_o)
      else $error("detach");
   AST_PU_PLUS:
   assert property (pullup_dplus_o |-> full_speed_o && $past(vbus_present_i))
      else $error("plus pull-up");
   AST_PU_MINUS:
   assert property (pullup_dminus_o |-> !full_speed_o && $past(vbus_present_i))
      else $error("minus pull-up");
   AST_ONE:
   assert property (wr_hit && reg_wdata_i[4:3] == 2'b01 |-> ##2 dplus_oe_o && dminus_oe_o
      && dplus_o && !dminus_o)
      else $error("forced one");
   AST_ZERO:
   assert property (wr_hit && reg_wdata_i[4:3] == 2'b10 |-> ##2 dplus_oe_o && dminus_oe_o
      && !dplus_o && dminus_o)
      else $error("forced zero");
   AST_SE0:
   assert property (wr_hit && reg_wdata_i[4:3] == 2'b11 |-> ##2 dplus_oe_o && dminus_oe_o
      && !dplus_o && !dminus_o)
      else $error("forced low");
   cover property (wr_hit && reg_wdata_i[7] && vbus_present_i);
   cover property (pullup_dminus_o);
   cover property (dplus_oe_o && dplus_o);
endmodule
bind usb_transceiver_control usb_xcvr_checker chk (.core_clk_i, .rst_i, .reg_addr_i,
   .reg_wr_i, .reg_wdata_i, .vbus_present_i, .dplus_o, .dplus_oe_o, .dminus_o,
   .dminus_oe_o, .phy_enable_o, .full_speed_o, .pullup_dplus_o, .pullup_dminus_o);
`default_nettype wire

/* verification/usb_transceiver_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Register and line test.
// ****
module usb_transceiver_control_test;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic vbus_present_i = 1'b0;
   logic ep_dir_in_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [3:0] ep_num_i = 4'h0;
   logic [2:0] host = 3'h0;
   logic [7:0] reg_rdata_o, ep_addr_o;
   logic [2:0] ep_pipe_o;
   logic dplus_i, dminus_i, diff_rx_i, dplus_o, dplus_oe_o, dminus_o, dminus_oe_o;
   logic phy_enable_o, full_speed_o, pullup_dplus_o, pullup_dminus_o, host_mode_o, ep_hit_o;
   logic [7:0] drv [4] = '{8'h00, 8'h0e, 8'h0d, 8'h0c};
   logic [2:0] lvl [4] = '{3'h0, 3'h6, 3'h1, 3'h0};
   wire logic [7:0] ctl = {3'h0, host_mode_o, phy_enable_o, full_speed_o, pullup_dplus_o,
      pullup_dminus_o};
   wire logic [7:0] drive = {4'h0, dplus_oe_o, dminus_oe_o, dplus_o & dplus_oe_o,
      dminus_o & dminus_oe_o};
   int fail_count = 0;
   int cmp_count = 0;
   always #2 core_clk_i = ~core_clk_i;
   usb_transceiver_control dut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
      .reg_wdata_i, .reg_rdata_o, .dplus_i, .dminus_i, .diff_rx_i, .vbus_present_i,
      .dplus_o, .dplus_oe_o, .dminus_o, .dminus_oe_o, .phy_enable_o, .full_speed_o,
      .pullup_dplus_o, .pullup_dminus_o, .host_mode_o, .ep_num_i, .ep_dir_in_i,
      .ep_hit_o, .ep_addr_o, .ep_pipe_o);
   usb_host_model host_side (.dplus_o, .dplus_oe_o, .dminus_o, .dminus_oe_o,
      .pullup_dplus_o, .pullup_dminus_o, .host_i(host), .dplus_i, .dminus_i, .diff_rx_i);
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d.", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input logic v,
      input logic [2:0] h);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      vbus_present_i <= v;
      host <= h;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [7:0] e, input string name);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check(name, reg_rdata_o, e);
   endtask
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end
   initial begin
      logic [3:0] n;
      int hits;
      hits = 0;
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      reg_read(8'hd7, 8'h00, "reset");
      reg_write(8'hd7, 8'he7, 1'b1, 3'h0);
      check("full", ctl, 8'h0e);
      reg_read(8'hd7, 8'he6, "full read");
      reg_write(8'hd7, 8'hc0, 1'b1, 3'h0);
      check("low", ctl, 8'h09);
      reg_read(8'hd7, 8'hc1, "low read");
      reg_write(8'hd7, 8'hc0, 1'b0, 3'h0);
      check("no power", ctl, 8'h08);
      reg_write(8'hd7, 8'h60, 1'b1, 3'h0);
      check("detach", ctl, 8'h0c);
      for (int m = 0; m < 4; m++) begin
         reg_write(8'hd7, {3'h2, 2'(m), 3'h7}, 1'b1, 3'h0);
         check("drive", drive, drv[m]);
         reg_read(8'hd7, {3'h2, 2'(m), lvl[m]}, "test read");
      end
      reg_write(8'hd7, 8'h20, 1'b1, 3'h6);
      check("phy off", ctl, 8'h04);
      reg_read(8'hd7, 8'h22, "phy off read");
      reg_write(8'hd6, 8'hff, 1'b1, 3'h5);
      reg_read(8'hd6, 8'h00, "unmapped");
      reg_read(8'hd7, 8'h21, "kept");
      for (int e = 0; e < 32; e++) begin
         @(posedge core_clk_i);
         ep_num_i <= 4'(e / 2);
         ep_dir_in_i <= e[0];
         @(posedge core_clk_i);
         #1;
         n = 4'(e / 2);
         hits += int'(ep_hit_o === 1'b1);
         check("ep addr", ep_addr_o, (n == 0 || n > 3) ? 8'h00 : {e[0], 3'h0, n});
         check("ep pipe", {4'h0, ep_hit_o, ep_pipe_o}, n > 3 ? 8'h00 : {5'h01, n[1:0], e[0]});
      end
      check("pipes", 8'(hits), 8'h08);
      print_verdict();
   end
endmodule
`default_nettype wire
